// file: core/ita_defs.svh
// Constants for the indirect-then-tally address modification block
`ifndef ITA_DEFS_SVH
`define ITA_DEFS_SVH

// ----------------------------------------------------------------
// Word layout (bit 35 of the doc numbering is index 0 here)
// ----------------------------------------------------------------
`define ITA_ADDR_MSB 35
`define ITA_ADDR_LSB 18
`define ITA_TLY_MSB  17
`define ITA_TLY_LSB  6
`define ITA_TAG_MSB  5
`define ITA_TAG_LSB  0
`define ITA_TMOD_MSB 5
`define ITA_TMOD_LSB 4
`define ITA_DSG_MSB  3
`define ITA_DSG_LSB  0
`define ITA_CP_MSB   2
`define ITA_CP_LSB   0
`define ITA_DLT_PAD  12'h000

// ----------------------------------------------------------------
// Tag modifier and designator codes
// ----------------------------------------------------------------
`define ITA_TM_REG     2'h0
`define ITA_TM_REG_PTR 2'h1
`define ITA_TM_TALLY   2'h2
`define ITA_TM_PTR_REG 2'h3
`define ITA_DSG_NONE   4'h0
`define ITA_V_ONE_HOP  4'h9
`define ITA_V_ASC      4'hE
`define ITA_V_DESC     4'hC
`define ITA_V_SEQ      4'hA
`define ITA_V_FIX      4'h8
`define ITA_V_PLUS     4'hB
`define ITA_V_MINUS    4'h4
`define ITA_V_TRAP     4'h0
`define ITA_V_ASC_CH   4'hF
`define ITA_V_DESC_CH  4'hD

// ----------------------------------------------------------------
// Character positions and arithmetic constants
// ----------------------------------------------------------------
`define ITA_CP_LAST6  3'h5
`define ITA_CP_LAST9  3'h3
`define ITA_CP_FIRST  3'h0
`define ITA_CP_ONE    3'h1
`define ITA_ACC_POS6  3'h5
`define ITA_ACC_POS9  3'h3
`define ITA_ONE18     18'h00001
`define ITA_ZERO18    18'h00000
`define ITA_ONE12     12'h001
`define ITA_ZERO12    12'h000
`define ITA_CNT_ONE   16'h0001

// ----------------------------------------------------------------
// APB register map and bits
// ----------------------------------------------------------------
`define ITA_REG_CTRL  8'h00
`define ITA_REG_STAT  8'h04
`define ITA_REG_CNT   8'h08
`define ITA_CTRL_C9   0
`define ITA_STAT_EXH  0
`define ITA_STAT_FLT  1
`define ITA_STAT_BSY  2
`define ITA_CTRL_RST  1'h0

`endif

// file: core/ita_pkg.sv
// Types for the indirect-then-tally address modification block
`include "ita_defs.svh"
package ita_pkg;

   // Sequencer states
   typedef enum logic [2:0] {
      ita_s_idle,
      ita_s_mod,
      ita_s_fetch_ptr,
      ita_s_fetch_tly,
      ita_s_tally,
      ita_s_write
   } ita_state_t;

   // What follows a tally word write-back
   typedef enum logic [1:0] {
      ita_p_done,
      ita_p_emit,
      ita_p_cont
   } ita_post_t;

   // Whole state of the main module
   typedef struct packed {
      ita_state_t  state;
      ita_post_t   post;
      logic        from_ptr_reg;
      logic [17:0] cur_addr;
      logic [5:0]  cur_tag;
      logic [17:0] saved_idx;
      logic [35:0] wrd;
      logic [3:0]  vcode;
      logic        exh_pend;
      logic        mem_req;
      logic        mem_we;
      logic [17:0] mem_addr;
      logic [35:0] mem_wdata;
      logic [17:0] ea;
      logic        ea_valid;
      logic        char_en;
      logic [2:0]  char_pos;
      logic        fault;
      logic        char9;
      logic        exh_flag;
      logic        fault_flag;
      logic [15:0] ref_cnt;
      logic [31:0] prdata;
      logic        pslverr;
   } ita_st_t;

endpackage : ita_pkg

// file: core/ita_upd.sv
// Field update arithmetic for a tally indirect word
`timescale 1ns/100ps
`include "ita_defs.svh"
module ita_upd
(
   input  wire logic [35:0] word,
   input  wire logic [3:0]  vcode,
   input  wire logic        char9,
   output logic      [35:0] new_word,
   output logic             tally_zero
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Tally steps wrap modulo 4096 by the 12-bit width
   function automatic logic [11:0] tly_step(input logic [11:0] t,
                                            input logic        up);
      tly_step = up ? t + `ITA_ONE12 : t - `ITA_ONE12;
   endfunction : tly_step

   logic [17:0] addr;
   logic [11:0] tly;
   logic [2:0]  cp;
   logic [17:0] delta;

   // ----------------------------------------------------------------
   // New address, tally and character position per variation
   // ----------------------------------------------------------------
   always_comb
   begin
      addr  = word[`ITA_ADDR_MSB:`ITA_ADDR_LSB];
      tly   = word[`ITA_TLY_MSB:`ITA_TLY_LSB];
      cp    = word[`ITA_CP_MSB:`ITA_CP_LSB];
      delta = {`ITA_DLT_PAD, word[`ITA_TAG_MSB:`ITA_TAG_LSB]};
      new_word = word;
      case (vcode)
         `ITA_V_ASC, `ITA_V_ASC_CH:
         begin
            addr = addr + `ITA_ONE18;
            tly  = tly_step(tly, 1'b0);
         end
         `ITA_V_DESC, `ITA_V_DESC_CH:
         begin
            addr = addr - `ITA_ONE18;
            tly  = tly_step(tly, 1'b1);
         end
         `ITA_V_PLUS:
         begin
            addr = addr + delta;
            tly  = tly_step(tly, 1'b0);
         end
         `ITA_V_MINUS:
         begin
            addr = addr - delta;
            tly  = tly_step(tly, 1'b1);
         end
         `ITA_V_SEQ:
         begin
            tly = tly_step(tly, 1'b0);
            // Word boundary: last position wraps and moves the address
            if (cp == (char9 ? `ITA_CP_LAST9 : `ITA_CP_LAST6))
            begin
               cp   = `ITA_CP_FIRST;
               addr = addr + `ITA_ONE18;
            end
            else
            begin
               cp = cp + `ITA_CP_ONE;
            end
         end
         default:
         begin
            addr = word[`ITA_ADDR_MSB:`ITA_ADDR_LSB];
         end
      endcase
      new_word[`ITA_ADDR_MSB:`ITA_ADDR_LSB] = addr;
      new_word[`ITA_TLY_MSB:`ITA_TLY_LSB]   = tly;
      if (vcode == `ITA_V_SEQ)
      begin
         new_word[`ITA_CP_MSB:`ITA_CP_LSB] = cp;
      end
      tally_zero = (tly == `ITA_ZERO12);
   end

endmodule : ita_upd

// file: core/ita_core.sv
// Indirect-then-tally effective address sequencer with APB registers
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "ita_defs.svh"

// How it works
// - one_hop uses indirect word, leaves it unchanged
// - one_hop ignores word's tag, chain ends
// - tag octal 51 does exactly one fetch
// - tag octal 60 fetches, saves zero index
// - ascend_count_down: address plus one, tally minus one
// - ascend_count_down: old address out, then update
// - ascend_count_down sets exhausted flag at zero
// - descend_count_up: address minus one, tally plus
// - descend_count_up updates before address goes out
// - descend_count_up tally 4096-j exhausts on j-th
// - sequential_char_step picks addressed character position
// - sequential_char_step: tally down, position up
// - last position wraps to zero, address plus
// - sequential_char_step updates after address goes out
// - sequential_char_step sets exhausted flag at zero
// - character lands at accumulator position 5/3
// - plus_stride adds delta, tally minus one
// - minus_stride subtracts delta, tally plus one
// - trap_variant leaves word, forces fault trap
// - ascend_and_chain updates, then continues chain
// - descend_and_chain updates, then continues chain
// - fixed_char_indirect picks character, no update
module ita_core
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        start,
   input  wire logic [17:0] start_addr,
   input  wire logic [5:0]  start_tag,
   output logic             busy,
   output logic      [3:0]  idx_sel,
   input  wire logic [17:0] idx_data,
   output logic             mem_req,
   output logic             mem_we,
   output logic      [17:0] mem_addr,
   output logic      [35:0] mem_wdata,
   input  wire logic [35:0] mem_rdata,
   input  wire logic        mem_ack,
   output logic             ea_valid,
   output logic      [17:0] ea,
   output logic             char_en,
   output logic      [2:0]  char_pos,
   output logic      [2:0]  acc_pos,
   output logic             fault_trap,
   output logic             count_exhausted
);

   // ----------------------------------------------------------------
   // State and helpers
   // ----------------------------------------------------------------
   ita_pkg::ita_st_t st;
   ita_pkg::ita_st_t next_st;

   logic [35:0] upd_word;
   logic        upd_zero;
   logic        set_exh;
   logic        set_flt;
   logic        clr_exh;
   logic        clr_flt;
   logic        emit;
   logic        wr_en;
   logic [17:0] idx;

   // Index for a designator; none means add zero
   function automatic logic [17:0] tag_index(input logic [5:0]  tag,
                                             input logic [17:0] val);
      if (tag[`ITA_DSG_MSB:`ITA_DSG_LSB] == `ITA_DSG_NONE)
         tag_index = `ITA_ZERO18;
      else
         tag_index = val;
   endfunction : tag_index

   // Address field of a 36-bit word
   function automatic logic [17:0] addr_of(input logic [35:0] w);
      addr_of = w[`ITA_ADDR_MSB:`ITA_ADDR_LSB];
   endfunction : addr_of

   // Register read mux
   function automatic logic [31:0] rd_word(input logic [7:0] a,
                                           input ita_pkg::ita_st_t s);
      rd_word = 32'h0000_0000;
      case (a)
         `ITA_REG_CTRL: rd_word[`ITA_CTRL_C9] = s.char9;
         `ITA_REG_STAT:
         begin
            rd_word[`ITA_STAT_EXH] = s.exh_flag;
            rd_word[`ITA_STAT_FLT] = s.fault_flag;
            rd_word[`ITA_STAT_BSY] = (s.state != ita_pkg::ita_s_idle);
         end
         `ITA_REG_CNT:  rd_word[15:0] = s.ref_cnt;
         default:       rd_word = 32'h0000_0000;
      endcase
   endfunction : rd_word

   // Address decode of the three words
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `ITA_REG_CTRL) || (a == `ITA_REG_STAT)
            || (a == `ITA_REG_CNT);
   endfunction : mapped

   // ----------------------------------------------------------------
   // Tally word arithmetic
   // ----------------------------------------------------------------
   ita_upd u_upd
   (
      .word       (st.wrd),
      .vcode      (st.vcode),
      .char9      (st.char9),
      .new_word   (upd_word),
      .tally_zero (upd_zero)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_st     = st;
      next_st.ea_valid = 1'b0;
      next_st.char_en  = 1'b0;
      next_st.fault    = 1'b0;
      set_exh = 1'b0;
      set_flt = 1'b0;
      emit    = 1'b0;
      idx     = tag_index(st.cur_tag, idx_data);

      // APB: latch answer in setup so the access phase is zero-wait
      wr_en = psel && penable && pwrite;
      if (psel && !penable)
      begin
         next_st.prdata  = rd_word(paddr, st);
         next_st.pslverr = !mapped(paddr);
      end
      clr_exh = wr_en && (paddr == `ITA_REG_STAT) && pwdata[`ITA_STAT_EXH];
      clr_flt = wr_en && (paddr == `ITA_REG_STAT) && pwdata[`ITA_STAT_FLT];
      if (wr_en && (paddr == `ITA_REG_CTRL))
      begin
         next_st.char9 = pwdata[`ITA_CTRL_C9];
      end

      case (st.state)
         ita_pkg::ita_s_idle:
         begin
            // Requests while busy are ignored
            if (start)
            begin
               next_st.cur_addr     = start_addr;
               next_st.cur_tag      = start_tag;
               next_st.saved_idx    = `ITA_ZERO18;
               next_st.from_ptr_reg = 1'b0;
               next_st.state        = ita_pkg::ita_s_mod;
            end
         end
         ita_pkg::ita_s_mod:
         begin
            next_st.mem_we = 1'b0;
            case (st.cur_tag[`ITA_TMOD_MSB:`ITA_TMOD_LSB])
               `ITA_TM_REG:
               begin
                  // Chain ends; a saved index wins over this one
                  next_st.ea = st.cur_addr
                             + (st.from_ptr_reg ? st.saved_idx : idx);
                  next_st.ea_valid = 1'b1;
                  emit             = 1'b1;
                  next_st.state    = ita_pkg::ita_s_idle;
               end
               `ITA_TM_REG_PTR:
               begin
                  next_st.mem_addr = st.cur_addr + idx;
                  next_st.mem_req  = 1'b1;
                  next_st.state    = ita_pkg::ita_s_fetch_ptr;
               end
               `ITA_TM_PTR_REG:
               begin
                  next_st.saved_idx    = idx;
                  next_st.from_ptr_reg = 1'b1;
                  next_st.mem_addr     = st.cur_addr;
                  next_st.mem_req      = 1'b1;
                  next_st.state        = ita_pkg::ita_s_fetch_ptr;
               end
               default:
               begin
                  // Tally type: one fetch of the tally word
                  next_st.vcode =
                     st.cur_tag[`ITA_DSG_MSB:`ITA_DSG_LSB];
                  next_st.mem_addr = st.cur_addr;
                  next_st.mem_req  = 1'b1;
                  next_st.state    = ita_pkg::ita_s_fetch_tly;
               end
            endcase
         end
         ita_pkg::ita_s_fetch_ptr:
         begin
            if (mem_ack)
            begin
               next_st.mem_req  = 1'b0;
               next_st.cur_addr = addr_of(mem_rdata);
               next_st.cur_tag  = mem_rdata[`ITA_TAG_MSB:`ITA_TAG_LSB];
               next_st.state    = ita_pkg::ita_s_mod;
            end
         end
         ita_pkg::ita_s_fetch_tly:
         begin
            if (mem_ack)
            begin
               next_st.mem_req = 1'b0;
               next_st.wrd     = mem_rdata;
               next_st.state   = ita_pkg::ita_s_tally;
            end
         end
         ita_pkg::ita_s_tally:
         begin
            next_st.mem_wdata = upd_word;
            next_st.mem_addr  = st.mem_addr;
            next_st.exh_pend  = upd_zero;
            next_st.post      = ita_pkg::ita_p_done;
            case (st.vcode)
               `ITA_V_ONE_HOP, `ITA_V_FIX:
               begin
                  // Word stays as fetched; its tag is never looked at
                  next_st.ea       = addr_of(st.wrd);
                  next_st.ea_valid = 1'b1;
                  next_st.char_en  = (st.vcode == `ITA_V_FIX);
                  next_st.char_pos = st.wrd[`ITA_CP_MSB:`ITA_CP_LSB];
                  emit             = 1'b1;
                  next_st.state    = ita_pkg::ita_s_idle;
               end
               `ITA_V_ASC, `ITA_V_PLUS, `ITA_V_SEQ:
               begin
                  // Old address goes out first, write-back follows
                  next_st.ea       = addr_of(st.wrd);
                  next_st.ea_valid = 1'b1;
                  next_st.char_en  = (st.vcode == `ITA_V_SEQ);
                  next_st.char_pos = st.wrd[`ITA_CP_MSB:`ITA_CP_LSB];
                  emit             = 1'b1;
                  next_st.mem_req  = 1'b1;
                  next_st.mem_we   = 1'b1;
                  next_st.state    = ita_pkg::ita_s_write;
               end
               `ITA_V_DESC, `ITA_V_MINUS:
               begin
                  // Update lands in memory before the address goes out
                  next_st.wrd     = upd_word;
                  next_st.post    = ita_pkg::ita_p_emit;
                  next_st.mem_req = 1'b1;
                  next_st.mem_we  = 1'b1;
                  next_st.state   = ita_pkg::ita_s_write;
               end
               `ITA_V_ASC_CH:
               begin
                  // Continue with the word as it was fetched
                  next_st.post    = ita_pkg::ita_p_cont;
                  next_st.mem_req = 1'b1;
                  next_st.mem_we  = 1'b1;
                  next_st.state   = ita_pkg::ita_s_write;
               end
               `ITA_V_DESC_CH:
               begin
                  next_st.wrd     = upd_word;
                  next_st.post    = ita_pkg::ita_p_cont;
                  next_st.mem_req = 1'b1;
                  next_st.mem_we  = 1'b1;
                  next_st.state   = ita_pkg::ita_s_write;
               end
               default:
               begin
                  // Trap and unused codes: no write, fault pulse
                  next_st.fault = 1'b1;
                  set_flt       = 1'b1;
                  next_st.state = ita_pkg::ita_s_idle;
               end
            endcase
         end
         ita_pkg::ita_s_write:
         begin
            if (mem_ack)
            begin
               next_st.mem_req = 1'b0;
               next_st.mem_we  = 1'b0;
               // Flag once the zero tally is stored
               set_exh = st.exh_pend;
               case (st.post)
                  ita_pkg::ita_p_emit:
                  begin
                     next_st.ea       = addr_of(st.wrd);
                     next_st.ea_valid = 1'b1;
                     emit             = 1'b1;
                     next_st.state    = ita_pkg::ita_s_idle;
                  end
                  ita_pkg::ita_p_cont:
                  begin
                     next_st.cur_addr = addr_of(st.wrd);
                     next_st.cur_tag  =
                        st.wrd[`ITA_TAG_MSB:`ITA_TAG_LSB];
                     next_st.state    = ita_pkg::ita_s_mod;
                  end
                  default:
                  begin
                     next_st.state = ita_pkg::ita_s_idle;
                  end
               endcase
            end
         end
         default:
         begin
            next_st.state = ita_pkg::ita_s_idle;
         end
      endcase

      // Sticky flags: a set in the clearing cycle wins
      next_st.exh_flag   = (st.exh_flag & ~clr_exh) | set_exh;
      next_st.fault_flag = (st.fault_flag & ~clr_flt) | set_flt;
      if (emit)
      begin
         next_st.ref_cnt = st.ref_cnt + `ITA_CNT_ONE;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         st <= '0;
      else
         st <= next_st;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Zero-wait slave: answer was latched in the setup cycle
   assign pready          = 1'b1;
   assign prdata          = st.prdata;
   assign pslverr         = st.pslverr;
   assign busy            = (st.state != ita_pkg::ita_s_idle);
   assign idx_sel         = st.cur_tag[`ITA_DSG_MSB:`ITA_DSG_LSB];
   assign mem_req         = st.mem_req;
   assign mem_we          = st.mem_we;
   assign mem_addr        = st.mem_addr;
   assign mem_wdata       = st.mem_wdata;
   assign ea_valid        = st.ea_valid;
   assign ea              = st.ea;
   assign char_en         = st.char_en;
   assign char_pos        = st.char_pos;
   assign acc_pos = st.char9 ? `ITA_ACC_POS9 : `ITA_ACC_POS6;
   assign fault_trap      = st.fault;
   assign count_exhausted = st.exh_flag;

endmodule : ita_core

// file: verification/ita_core_asserts.sv
// Port checker for the indirect tally sequencer
`timescale 1ns/100ps
module ita_core_chk
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        start,
   input wire logic [5:0]  start_tag,
   input wire logic        busy,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [35:0] mem_wdata,
   input wire logic [35:0] mem_rdata,
   input wire logic        mem_ack,
   input wire logic        ea_valid,
   input wire logic [17:0] ea,
   input wire logic        char_en,
   input wire logic [2:0]  char_pos,
   input wire logic        fault_trap,
   input wire logic        count_exhausted
);
   // ---------------------------------------------
   // Sequencing properties
   // ---------------------------------------------
   logic [5:0] tag_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Tag of the request that was really taken
   always_ff @(posedge clk or posedge rst)
      if (rst)
         tag_q <= 6'h00;
      else if (start && !busy)
         tag_q <= start_tag;
   property p_hop_ro;
      busy && tag_q == 6'h29 |-> !(mem_req && mem_we);
   endproperty
   a_hop_ro: assert property (p_hop_ro) else $error("hop wrote");
   property p_hop_ea;
      tag_q == 6'h29 && mem_ack |-> ##2
         ea_valid && !busy && ea == $past(mem_rdata[35:18], 2);
   endproperty
   a_hop_ea: assert property (p_hop_ea) else $error("hop ea");
   property p_asc_wr;
      tag_q == 6'h2E && mem_ack && !mem_we |-> ##2 mem_req && mem_we &&
         mem_wdata == {$past(mem_rdata[35:18], 2) + 18'h00001,
         $past(mem_rdata[17:6], 2) - 12'h001, $past(mem_rdata[5:0], 2)};
   endproperty
   a_asc_wr: assert property (p_asc_wr) else $error("asc word");
   property p_asc_ea;
      tag_q == 6'h2E && mem_ack && !mem_we |-> ##2
         ea_valid && ea == $past(mem_rdata[35:18], 2);
   endproperty
   a_asc_ea: assert property (p_asc_ea) else $error("asc ea");
   property p_exh;
      $rose(count_exhausted) |->
         $past(mem_ack && mem_we && mem_wdata[17:6] == 12'h000);
   endproperty
   a_exh: assert property (p_exh) else $error("exhaust");
   property p_desc_ea;
      tag_q == 6'h2C && mem_ack && mem_we |=>
         ea_valid && ea == $past(mem_wdata[35:18]);
   endproperty
   a_desc_ea: assert property (p_desc_ea) else $error("desc ea");
   property p_seq_ch;
      tag_q == 6'h2A && mem_ack && !mem_we |-> ##2
         ea_valid && char_en && char_pos == $past(mem_rdata[2:0], 2);
   endproperty
   a_seq_ch: assert property (p_seq_ch) else $error("seq char");
   property p_trap;
      tag_q == 6'h20 && mem_ack |-> ##2 fault_trap && !ea_valid;
   endproperty
   a_trap: assert property (p_trap) else $error("trap");
   c_char: cover property (ea_valid && char_en);
   c_trap: cover property (fault_trap);
   c_exh: cover property ($rose(count_exhausted));
endmodule : ita_core_chk
bind ita_core ita_core_chk u_ita_core_chk (.*);

// file: verification/ita_mem_model.sv
// Behavioural main memory holding the indirect words
`timescale 1ns/100ps
module ita_mem_model
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        slow,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [17:0] mem_addr,
   input  wire logic [35:0] mem_wdata,
   output logic      [35:0] mem_rdata,
   output logic             mem_ack
);
   // ---------------------------------------------
   // Storage and handshake
   // ---------------------------------------------
   logic [35:0] mem [256];
   logic [1:0]  wait_cnt;
   // Read data toggles outside the ack cycle so stale reads show up
   always @(posedge clk or posedge rst)
      if (rst)
      begin
         mem_ack   <= 1'b0;
         wait_cnt  <= 2'h0;
         mem_rdata <= 36'h0;
      end
      else
      begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack)
         begin
            wait_cnt <= wait_cnt + 2'h1;
            if (wait_cnt >= {slow, 1'b0})
            begin
               wait_cnt <= 2'h0;
               mem_ack  <= 1'b1;
               if (mem_we)
                  mem[mem_addr[7:0]] <= mem_wdata;
               else
                  mem_rdata <= mem[mem_addr[7:0]];
            end
         end
      end
endmodule : ita_mem_model

// file: verification/testbench.sv
// Self-checking bench for the indirect tally sequencer
`timescale 1ns/100ps
module testbench;
   // ---------------------------------------------
   // Signals, instances and tasks
   // ---------------------------------------------
   logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic        start = 0, slow = 0, c9, er, pready, pslverr, busy;
   logic        mem_req, mem_we, mem_ack, ea_valid, char_en;
   logic        fault_trap, count_exhausted;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [17:0] start_addr = 18'h0, idx_data = 18'h0, mem_addr, ea;
   logic [5:0]  start_tag = 6'h00;
   logic [3:0]  idx_sel, cd;
   logic [35:0] mem_wdata, mem_rdata, w;
   logic [2:0]  char_pos, acc_pos;
   int          error_cnt = 0, checked = 0, seed = 26, n_ea = 0;
   logic [3:0]  codes [10] = '{4'h9, 4'hE, 4'hC, 4'hA, 4'h8, 4'hB, 4'h4,
      4'h0, 4'hF, 4'hD};
   ita_core u_ita_core (.*);
   ita_mem_model u_ita_mem_model (.*);
   always #10 clk = ~clk;
   task cmp(input logic [35:0] g, input logic [35:0] e);
      checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Reference model of one request, then the design run beside it
   task run(input logic [5:0] tag, input logic [35:0] wd);
      logic [17:0] na, ex, gea;
      logic [11:0] nt;
      logic [2:0]  nc, gcp, lst;
      logic [3:0]  v;
      logic        gf;
      int          n;
      v = tag[5:4] == 2'h2 ? tag[3:0] : 4'h9;
      lst = c9 ? 3'h3 : 3'h5;
      na = wd[35:18];
      nt = (v[2:1] == 2'h2) ? wd[17:6] + 12'h001
         : (v[3] && v[1]) ? wd[17:6] - 12'h001
         : wd[17:6];
      case (v)
         4'hE, 4'hF: na = na + 18'h00001;
         4'hC, 4'hD: na = na - 18'h00001;
         4'hB: na = na + wd[5:0];
         4'h4: na = na - wd[5:0];
         4'hA: na = na + 18'(wd[2:0] == lst);
      endcase
      nc = (v != 4'hA) ? wd[2:0] : (wd[2:0] == lst) ? 3'h0 : wd[2:0] + 3'h1;
      ex = (v[2:1] == 2'h2) ? na : wd[35:18];
      u_ita_mem_model.mem[8'h20] = wd;
      @(posedge clk);
      start      <= 1'b1;
      start_addr <= 18'h00020;
      start_tag  <= tag;
      slow       <= $random(seed);
      idx_data   <= $random(seed);
      @(posedge clk);
      start <= 1'b0;
      gea = 'x;
      gcp = 'x;
      gf = 1'b0;
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
         if (ea_valid === 1'b1)
            gea = ea;
         if (char_en === 1'b1)
            gcp = char_pos;
         if (fault_trap === 1'b1)
            gf = 1'b1;
      end
      while (busy !== 1'b0 && n < 300);
      cmp(gf, v == 4'h0);
      if (v != 4'h0)
         cmp(gea, ex);
      if (v == 4'hA || v == 4'h8)
         cmp(gcp, wd[2:0]);
      cmp(u_ita_mem_model.mem[8'h20], {na, nt, wd[5:3], nc});
      cmp(count_exhausted, nt != wd[17:6] && nt == 12'h0);
      cmp(acc_pos, lst);
      apb(1'b0, 8'h04, 32'h0);
      cmp(rd, {v == 4'h0, count_exhausted});
      apb(1'b1, 8'h04, 32'h3);
      n_ea += (v != 4'h0);
   endtask : run
   task tally_and_finish;
      if (error_cnt == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish
   // Main sequence: every variant, first pass at tally and position edges
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 64; i++)
      begin
         w = {$random(seed), $random(seed)};
         c9 = $random(seed);
         cd = codes[i % 10];
         if (cd == 4'hA || cd == 4'h8)
            w[2:0] = i < 8 ? 3'h5 - {c9, 1'b0} : 3'({$random(seed)} % 4);
         if (i < 10)
            w[17:6] = (cd[2:1] == 2'h2) ? 12'hFFF : 12'h001;
         if (cd[3:2] == 2'h3 && cd[0])
            w[5:0] = 6'h00;
         apb(1'b1, 8'h00, {31'h0, c9});
         run({2'h2, cd}, w);
      end
      w[5:0] = 6'h00;
      run(6'h10, w);
      run(6'h30, w);
      apb(1'b0, 8'h08, 32'h0);
      cmp(rd, n_ea);
      apb(1'b0, 8'h0C, 32'h0);
      cmp({er, rd}, 33'h100000000);
      tally_and_finish;
   end
   // Cuts a hang short well past the expected run length
   initial
   begin
      #1000000;
      error_cnt++;
      tally_and_finish;
   end
endmodule : testbench
